// File: include/mio_pkg.sv
// Constants, bus-type codes and the output source enumeration of the multimode I/O port block
`default_nettype none
package mio_pkg;
    localparam int PORT_W = 8;
    localparam int PORTD_W = 3;
    localparam int NUM_PORTS = 4;
    // Register selectors on the host register port
    localparam logic [2:0] SEL_CONTROL = 3'h0;
    localparam logic [2:0] SEL_DIRECTION = 3'h1;
    localparam logic [2:0] SEL_DRIVE = 3'h2;
    localparam logic [2:0] SEL_DATA_OUT = 3'h3;
    localparam logic [2:0] SEL_DATA_IN = 3'h4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] PORTD_MASK = 8'h07;
    // Nonvolatile host bus type
    localparam logic [1:0] BUS_MUX8 = 2'h0;
    localparam logic [1:0] BUS_NONMUX8 = 2'h1;
    localparam logic [1:0] BUS_PAGED = 2'h2;
    localparam logic [1:0] BUS_MUX8_HI = 2'h3;
    typedef enum logic [2:0] {
        MIO_SRC_DATA_OUT,
        MIO_SRC_ADDRESS,
        MIO_SRC_MACROCELL,
        MIO_SRC_CHIP_SELECT,
        MIO_SRC_HOST_DATA
    } mio_src_t;
endpackage
`default_nettype wire

// File: core/mio_pin_port.sv
// One I/O port: per-pin output mux, enable and data-in read path
`default_nettype none
module mio_pin_port #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [W-1:0] control,
    input wire logic [W-1:0] direction,
    input wire logic [W-1:0] data_out,
    input wire logic [W-1:0] latched_address,
    input wire logic [W-1:0] macrocell_out,
    input wire logic [W-1:0] chip_select_out,
    input wire logic [W-1:0] host_data,
    input wire logic [W-1:0] oe_term,
    input wire logic [W-1:0] logic_array_pin,
    input wire logic [W-1:0] chip_select_pin,
    input wire logic [W-1:0] pin_in,
    input wire logic gpio_disable,
    input wire logic bus_drive,
    input wire logic bus_enable,
    output logic [W-1:0] pin_out,
    output logic [W-1:0] pin_oe,
    output logic [W-1:0] data_in
);
    import mio_pkg::*;
    logic [W-1:0] next_out;
    logic [W-1:0] next_oe;

    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (bus_enable) begin
                next_out[i] = host_data[i];
                next_oe[i] = bus_drive;
            end else if (gpio_disable) begin
                next_out[i] = 1'b0;
                next_oe[i] = 1'b0;
            end else if (chip_select_pin[i]) begin
                next_out[i] = chip_select_out[i];
                next_oe[i] = oe_term[i] | direction[i];
            end else if (logic_array_pin[i]) begin
                next_out[i] = macrocell_out[i];
                next_oe[i] = oe_term[i] | direction[i];
            end else if (control[i]) begin
                next_out[i] = latched_address[i];
                next_oe[i] = oe_term[i] | (control[i] & direction[i]);
            end else begin
                next_out[i] = data_out[i];
                next_oe[i] = oe_term[i] | direction[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_out <= '0;
            pin_oe <= '0;
        end else begin
            pin_out <= next_out;
            pin_oe <= next_oe;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_in <= '0;
        end else begin
            data_in <= pin_in;
        end
    end
endmodule
`default_nettype wire

// File: core/mio_port_ctrl.sv
// Top of the four-port multimode I/O block: registers, address latch and port instances
`default_nettype none
module mio_port_ctrl (
    input wire logic core_clk,
    input wire logic rst,
    // Host register port
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [1:0] host_port,
    input wire logic [2:0] host_sel,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // Host bus
    input wire logic address_strobe,
    input wire logic [15:0] host_addr,
    input wire logic [7:0] host_bus_data,
    input wire logic host_bus_read,
    // Nonvolatile configuration
    input wire logic [1:0] cfg_bus_type,
    input wire logic cfg_data_port,
    input wire logic [7:0] cfg_logic_array_a,
    input wire logic [7:0] cfg_logic_array_b,
    input wire logic [7:0] cfg_logic_array_c,
    input wire logic [2:0] cfg_logic_array_d,
    input wire logic [2:0] cfg_chip_select_d,
    input wire logic [7:0] cfg_address_in_a,
    input wire logic [7:0] cfg_address_in_b,
    input wire logic [7:0] cfg_address_in_c,
    input wire logic [2:0] cfg_address_in_d,
    input wire logic cfg_test_port,
    // Memory mode register bit and select terms
    input wire logic peripheral_mode_enable_bit,
    input wire logic peripheral_select_0,
    input wire logic peripheral_select_1,
    input wire logic test_port_select_input,
    input wire logic test_port_enable_bit,
    // Logic array
    input wire logic [7:0] macrocell_group_first,
    input wire logic [7:0] macrocell_group_second,
    input wire logic [2:0] decode_chip_select,
    input wire logic [7:0] oe_term_a,
    input wire logic [7:0] oe_term_b,
    input wire logic [7:0] oe_term_c,
    input wire logic [2:0] oe_term_d,
    // Pins
    input wire logic [7:0] pin_in_a,
    input wire logic [7:0] pin_in_b,
    input wire logic [7:0] pin_in_c,
    input wire logic [2:0] pin_in_d,
    output logic [7:0] pin_out_a,
    output logic [7:0] pin_out_b,
    output logic [7:0] pin_out_c,
    output logic [2:0] pin_out_d,
    output logic [7:0] pin_oe_a,
    output logic [7:0] pin_oe_b,
    output logic [7:0] pin_oe_c,
    output logic [2:0] pin_oe_d,
    // Input macrocells and drive settings
    output logic [7:0] address_in_a,
    output logic [7:0] address_in_b,
    output logic [7:0] address_in_c,
    output logic [2:0] address_in_d,
    output logic [7:0] drive_a,
    output logic [7:0] drive_b,
    output logic [7:0] drive_c,
    output logic [2:0] drive_d,
    output logic test_port_active
);
    import mio_pkg::*;
    logic [7:0] control [2];
    logic [7:0] direction [4];
    logic [7:0] data_out [4];
    logic [7:0] addr_latch;
    logic [7:0] addr_a;
    logic [7:0] addr_b;
    logic [7:0] data_in_a;
    logic [7:0] data_in_b;
    logic [7:0] data_in_c;
    logic [2:0] data_in_d;
    logic [7:0] dir_c;
    logic [7:0] dir_d;
    logic port_a_bus_drive;
    logic periph_on;
    logic periph_sel;
    logic [7:0] next_rdata;

    // Register writes, captured on the host strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            control[0] <= REG_RESET;
            control[1] <= REG_RESET;
            for (int p = 0; p < NUM_PORTS; p++) begin
                direction[p] <= REG_RESET;
                data_out[p] <= REG_RESET;
            end
        end else if (host_wr) begin
            if (host_sel == SEL_CONTROL && host_port < 2'd2) begin
                control[host_port[0]] <= host_wdata;
            end else if (host_sel == SEL_DIRECTION) begin
                direction[host_port] <= (host_port == 2'd3) ? (host_wdata & PORTD_MASK) : host_wdata;
            end else if (host_sel == SEL_DATA_OUT) begin
                data_out[host_port] <= (host_port == 2'd3) ? (host_wdata & PORTD_MASK) : host_wdata;
            end
        end
    end

    // Drive select registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_a <= REG_RESET;
            drive_b <= REG_RESET;
            drive_c <= REG_RESET;
            drive_d <= REG_RESET[2:0];
        end else if (host_wr && host_sel == SEL_DRIVE) begin
            if (host_port == 2'd0) begin
                drive_a <= host_wdata;
            end else if (host_port == 2'd1) begin
                drive_b <= host_wdata;
            end else if (host_port == 2'd2) begin
                drive_c <= host_wdata;
            end else begin
                drive_d <= host_wdata[2:0];
            end
        end
    end

    // Low address byte latch on the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            addr_latch <= '0;
        end else begin
            if (address_strobe) begin
                addr_latch <= (cfg_bus_type == BUS_NONMUX8) ? host_addr[7:0] : host_bus_data;
            end
        end
    end

    // Address output assignment per bus type
    always_comb begin
        if (cfg_bus_type == BUS_NONMUX8) begin
            addr_a = '0;
            addr_b = host_addr[7:0];
        end else if (cfg_bus_type == BUS_PAGED) begin
            addr_a = '0;
            addr_b = host_addr[15:8];
        end else if (cfg_bus_type == BUS_MUX8_HI) begin
            addr_a = {addr_latch[7:4], 4'h0};
            addr_b = {4'h0, host_addr[11:8]};
        end else begin
            addr_a = addr_latch;
            addr_b = addr_latch;
        end
    end

    // Input macrocells latch address inputs on the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            address_in_a <= '0;
            address_in_b <= '0;
            address_in_c <= '0;
            address_in_d <= '0;
        end else if (address_strobe) begin
            address_in_a <= pin_in_a & cfg_address_in_a;
            address_in_b <= pin_in_b & cfg_address_in_b;
            address_in_c <= pin_in_c & cfg_address_in_c;
            address_in_d <= pin_in_d & cfg_address_in_d;
        end
    end

    assign periph_on = peripheral_mode_enable_bit & ~cfg_data_port;
    assign periph_sel = peripheral_select_0 | peripheral_select_1;
    assign port_a_bus_drive = cfg_data_port ? host_bus_read : (periph_sel & host_bus_read);
    assign dir_c = direction[2];
    assign dir_d = direction[3];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            test_port_active <= 1'b0;
        end else begin
            test_port_active <= test_port_select_input | cfg_test_port | test_port_enable_bit;
        end
    end

    mio_pin_port #(.W(PORT_W)) u_port_a (
        .core_clk(core_clk),
        .rst(rst),
        .control(control[0]),
        .direction(direction[0]),
        .data_out(data_out[0]),
        .latched_address(addr_a),
        .macrocell_out(macrocell_group_first),
        .chip_select_out(8'h00),
        .host_data(host_bus_data),
        .oe_term(oe_term_a),
        .logic_array_pin(cfg_logic_array_a),
        .chip_select_pin(8'h00),
        .pin_in(pin_in_a),
        .gpio_disable(cfg_data_port),
        .bus_drive(port_a_bus_drive),
        .bus_enable(cfg_data_port | periph_on),
        .pin_out(pin_out_a),
        .pin_oe(pin_oe_a),
        .data_in(data_in_a)
    );

    mio_pin_port #(.W(PORT_W)) u_port_b (
        .core_clk(core_clk),
        .rst(rst),
        .control(control[1]),
        .direction(direction[1]),
        .data_out(data_out[1]),
        .latched_address(addr_b),
        .macrocell_out(macrocell_group_first),
        .chip_select_out(8'h00),
        .host_data(8'h00),
        .oe_term(oe_term_b),
        .logic_array_pin(cfg_logic_array_b),
        .chip_select_pin(8'h00),
        .pin_in(pin_in_b),
        .gpio_disable(1'b0),
        .bus_drive(1'b0),
        .bus_enable(1'b0),
        .pin_out(pin_out_b),
        .pin_oe(pin_oe_b),
        .data_in(data_in_b)
    );

    mio_pin_port #(.W(PORT_W)) u_port_c (
        .core_clk(core_clk),
        .rst(rst),
        .control(8'h00),
        .direction(dir_c),
        .data_out(data_out[2]),
        .latched_address(8'h00),
        .macrocell_out(macrocell_group_second),
        .chip_select_out(8'h00),
        .host_data(8'h00),
        .oe_term(oe_term_c),
        .logic_array_pin(cfg_logic_array_c),
        .chip_select_pin(8'h00),
        .pin_in(pin_in_c),
        .gpio_disable(1'b0),
        .bus_drive(1'b0),
        .bus_enable(1'b0),
        .pin_out(pin_out_c),
        .pin_oe(pin_oe_c),
        .data_in(data_in_c)
    );

    mio_pin_port #(.W(PORTD_W)) u_port_d (
        .core_clk(core_clk),
        .rst(rst),
        .control(3'h0),
        .direction(dir_d[2:0]),
        .data_out(data_out[3][2:0]),
        .latched_address(3'h0),
        .macrocell_out(3'h0),
        .chip_select_out(decode_chip_select),
        .host_data(3'h0),
        .oe_term(oe_term_d),
        .logic_array_pin(cfg_logic_array_d),
        .chip_select_pin(cfg_chip_select_d),
        .pin_in(pin_in_d),
        .gpio_disable(1'b0),
        .bus_drive(1'b0),
        .bus_enable(1'b0),
        .pin_out(pin_out_d),
        .pin_oe(pin_oe_d),
        .data_in(data_in_d)
    );

    // Read path: register contents or sampled pin levels
    always_comb begin
        next_rdata = 8'h00;
        if (host_sel == SEL_CONTROL) begin
            next_rdata = (host_port < 2'd2) ? control[host_port[0]] : 8'h00;
        end else if (host_sel == SEL_DIRECTION) begin
            next_rdata = direction[host_port];
        end else if (host_sel == SEL_DATA_OUT) begin
            next_rdata = data_out[host_port];
        end else if (host_sel == SEL_DRIVE) begin
            if (host_port == 2'd0) begin
                next_rdata = drive_a;
            end else if (host_port == 2'd1) begin
                next_rdata = drive_b;
            end else if (host_port == 2'd2) begin
                next_rdata = drive_c;
            end else begin
                next_rdata = {5'h00, drive_d};
            end
        end else if (host_sel == SEL_DATA_IN) begin
            if (host_port == 2'd0) begin
                next_rdata = cfg_data_port ? 8'h00 : data_in_a;
            end else if (host_port == 2'd1) begin
                next_rdata = data_in_b;
            end else if (host_port == 2'd2) begin
                next_rdata = data_in_c;
            end else begin
                next_rdata = {5'h00, data_in_d};
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            host_rdata <= 8'h00;
        end else if (host_rd) begin
            host_rdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// File: sim/mio_pin_model.sv
// Pin-level model of the lines and parts outside one port
`default_nettype none
module mio_pin_model #(
    parameter int W = 8
) (
    input wire logic core_clk,
    input wire logic [W-1:0] pin_out,
    input wire logic [W-1:0] pin_oe,
    input wire logic [W-1:0] ext,
    input wire logic [W-1:0] ext_en,
    output logic [W-1:0] pin_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [W-1:0] float_q = '0;
    // A line nobody drives has no pull, so it wanders instead of keeping its last level
    always @(posedge core_clk) float_q <= ~float_q;
    // The port wins where it drives, outside parts drive where enabled
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext) | (~pin_oe & ~ext_en & float_q);
endmodule
`default_nettype wire

// File: sim/mio_port_ctrl_properties.sv
// Checker for the multimode I/O port block, bound to its top module
`default_nettype none
module mio_port_ctrl_properties
    import mio_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [1:0] host_port,
    input wire logic [2:0] host_sel,
    input wire logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic address_strobe,
    input wire logic host_bus_read,
    input wire logic cfg_data_port,
    input wire logic cfg_test_port,
    input wire logic [2:0] cfg_address_in_d,
    input wire logic peripheral_mode_enable_bit,
    input wire logic peripheral_select_0,
    input wire logic peripheral_select_1,
    input wire logic test_port_select_input,
    input wire logic test_port_enable_bit,
    input wire logic [7:0] oe_term_b,
    input wire logic [2:0] pin_in_d,
    input wire logic [7:0] pin_oe_a,
    input wire logic [7:0] pin_oe_b,
    input wire logic [2:0] address_in_d,
    input wire logic [7:0] drive_a,
    input wire logic test_port_active
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    property p_reset_clear;
        disable iff (1'b0) rst |=> host_rdata == 8'h00 && pin_oe_a == 8'h00 && pin_oe_b == 8'h00 && drive_a == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared by reset");
    property p_readback;
        host_wr && host_sel == SEL_DIRECTION && host_port == 2'h0 ##1 !host_wr ##1
        host_rd && !host_wr && host_sel == SEL_DIRECTION && host_port == 2'h0 |=> host_rdata == $past(host_wdata, 3);
    endproperty
    a_readback: assert property (p_readback) else $error("direction read does not return written value");
    property p_no_control;
        host_rd && host_sel == SEL_CONTROL && host_port[1] |=> host_rdata == 8'h00;
    endproperty
    a_no_control: assert property (p_no_control) else $error("control read on port without control");
    property p_oe_term;
        (oe_term_b == 8'hff) [*3] |-> pin_oe_b == 8'hff;
    endproperty
    a_oe_term: assert property (p_oe_term) else $error("enable term does not drive pins");
    property p_periph_idle;
        (peripheral_mode_enable_bit && !peripheral_select_0 && !peripheral_select_1 && !cfg_data_port) [*3] |->
        pin_oe_a == 8'h00;
    endproperty
    a_periph_idle: assert property (p_periph_idle) else $error("peripheral buffer drives without select");
    property p_data_port;
        (cfg_data_port && host_bus_read) [*3] |-> pin_oe_a == 8'hff;
    endproperty
    a_data_port: assert property (p_data_port) else $error("data port not driving on read");
    property p_test_port;
        (test_port_select_input || cfg_test_port || test_port_enable_bit) [*2] |=> test_port_active;
    endproperty
    a_test_port: assert property (p_test_port) else $error("test port not enabled");
    property p_addr_in;
        address_strobe && cfg_address_in_d == 3'h7 |=> address_in_d == $past(pin_in_d);
    endproperty
    a_addr_in: assert property (p_addr_in) else $error("address input not captured on strobe");
    c_addr_in: cover property (address_strobe && cfg_address_in_d == 3'h7);
    c_periph: cover property (peripheral_mode_enable_bit && peripheral_select_1 && host_bus_read);
    c_data_port: cover property (cfg_data_port && host_bus_read);
endmodule
bind mio_port_ctrl mio_port_ctrl_properties mio_port_ctrl_properties_i (.*);
`default_nettype wire

// File: sim/tb_multimode_io_port_control.sv
// Self-checking testbench for the multimode I/O port block
`default_nettype none
module tb_multimode_io_port_control;
    timeunit 1ns;
    timeprecision 100ps;
    import mio_pkg::*;
    logic core_clk, rst, host_wr, host_rd, address_strobe, host_bus_read, cfg_data_port, cfg_test_port;
    logic peripheral_mode_enable_bit, peripheral_select_0, peripheral_select_1;
    logic test_port_select_input, test_port_enable_bit, test_port_active;
    logic [1:0] host_port, cfg_bus_type;
    logic [2:0] host_sel, cfg_logic_array_d, cfg_chip_select_d, cfg_address_in_d, decode_chip_select, oe_term_d;
    logic [2:0] pin_in_d, pin_out_d, pin_oe_d, address_in_d, drive_d, ext_d, ext_en_d;
    logic [7:0] host_wdata, host_rdata, host_bus_data, cfg_logic_array_a, cfg_logic_array_b, cfg_logic_array_c;
    logic [7:0] cfg_address_in_a, cfg_address_in_b, cfg_address_in_c, macrocell_group_first, macrocell_group_second;
    logic [7:0] oe_term_a, oe_term_b, oe_term_c, pin_in_a, pin_in_b, pin_in_c, pin_out_a, pin_out_b, pin_out_c;
    logic [7:0] pin_oe_a, pin_oe_b, pin_oe_c, address_in_a, address_in_b, address_in_c, drive_a, drive_b, drive_c;
    logic [7:0] ext_a, ext_en_a, ext_b, ext_en_b, ext_c, ext_en_c;
    logic [15:0] host_addr;
    int num_errors;
    int checked;

    mio_port_ctrl mio_port_ctrl_i (.*);
    mio_pin_model #(.W(8)) pm_a (.core_clk, .pin_out(pin_out_a), .pin_oe(pin_oe_a), .ext(ext_a), .ext_en(ext_en_a),
        .pin_in(pin_in_a));
    mio_pin_model #(.W(8)) pm_b (.core_clk, .pin_out(pin_out_b), .pin_oe(pin_oe_b), .ext(ext_b), .ext_en(ext_en_b),
        .pin_in(pin_in_b));
    mio_pin_model #(.W(8)) pm_c (.core_clk, .pin_out(pin_out_c), .pin_oe(pin_oe_c), .ext(ext_c), .ext_en(ext_en_c),
        .pin_in(pin_in_c));
    mio_pin_model #(.W(3)) pm_d (.core_clk, .pin_out(pin_out_d), .pin_oe(pin_oe_d), .ext(ext_d), .ext_en(ext_en_d),
        .pin_in(pin_in_d));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [1:0] p, input logic [2:0] s, input logic [7:0] d);
        host_port = p;
        host_sel = s;
        host_wdata = d;
        host_wr = 1'b1;
        @(negedge core_clk);
        host_wr = 1'b0;
        @(negedge core_clk);
    endtask
    task automatic rchk(input logic [1:0] p, input logic [2:0] s, input logic [7:0] exp);
        host_port = p;
        host_sel = s;
        host_rd = 1'b1;
        @(negedge core_clk);
        host_rd = 1'b0;
        @(negedge core_clk);
        chk($sformatf("register %0d.%0d", p, s), host_rdata, exp);
    endtask
    task automatic settle();
        repeat (4) @(negedge core_clk);
    endtask
    task automatic strobe();
        address_strobe = 1'b1;
        @(negedge core_clk);
        address_strobe = 1'b0;
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset();
        for (int p = 0; p < 4; p++) begin
            for (int s = 0; s < 4; s++) begin
                rchk(p[1:0], s[2:0], 8'h00);
            end
        end
        chk("drive", {drive_a, drive_b, drive_c, drive_d}, 32'h0);
        chk("pin oe", {pin_oe_a, pin_oe_b, pin_oe_c, pin_oe_d}, 32'h0);
    endtask
    task automatic t_gpio();
        ext_a = 8'h3c;
        ext_en_a = 8'hf0;
        wr(2'h0, SEL_CONTROL, 8'h00);
        wr(2'h0, SEL_DATA_OUT, 8'ha5);
        wr(2'h0, SEL_DIRECTION, 8'h0f);
        rchk(2'h0, SEL_DIRECTION, 8'h0f);
        settle();
        chk("oe a", pin_oe_a, 8'h0f);
        chk("out a", pin_out_a & 8'h0f, 8'h05);
        rchk(2'h0, SEL_DATA_IN, 8'h35);
        rchk(2'h0, SEL_DATA_OUT, 8'ha5);
    endtask
    task automatic t_refuse();
        wr(2'h2, SEL_CONTROL, 8'hff);
        rchk(2'h2, SEL_CONTROL, 8'h00);
        wr(2'h3, SEL_DRIVE, 8'hff);
        rchk(2'h3, SEL_DRIVE, 8'h07);
        settle();
        chk("oe c", pin_oe_c, 8'h00);
        chk("drive d", drive_d, 3'h7);
    endtask
    task automatic t_logic_array();
        cfg_logic_array_c = 8'hff;
        macrocell_group_second = 8'h96;
        oe_term_c = 8'hf0;
        ext_c = 8'h04;
        ext_en_c = 8'h0c;
        // Array pins 7-4 and 1-0 drive and pins 3-2 are driven from outside, so direction is set on pins 1-0 only
        wr(2'h2, SEL_DIRECTION, 8'h03);
        settle();
        chk("array oe c", pin_oe_c, 8'hf3);
        chk("array out c", pin_out_c & 8'hf3, 8'h92);
        rchk(2'h2, SEL_DATA_IN, 8'h96);
    endtask
    task automatic t_addr_out();
        cfg_bus_type = BUS_MUX8;
        wr(2'h1, SEL_CONTROL, 8'hff);
        host_bus_data = 8'h5a;
        strobe();
        host_bus_data = 8'h11;
        settle();
        chk("addr oe idle", pin_oe_b, 8'h00);
        oe_term_b = 8'hff;
        settle();
        chk("addr mux", {pin_oe_b, pin_out_b}, 16'hff5a);
        oe_term_b = 8'h00;
        // Address pins feed no boot memory here, so run-time enabling is safe
        wr(2'h1, SEL_DIRECTION, 8'hff);
        host_addr = 16'hbeef;
        cfg_bus_type = BUS_NONMUX8;
        settle();
        chk("addr nonmux", {pin_oe_b, pin_out_b}, 16'hffef);
        cfg_bus_type = BUS_PAGED;
        settle();
        chk("addr paged", pin_out_b, 8'hbe);
        cfg_bus_type = BUS_MUX8_HI;
        settle();
        chk("addr mux hi", pin_out_b, 8'h0e);
    endtask
    task automatic t_addr_in();
        cfg_address_in_d = 3'h7;
        ext_en_d = 3'h7;
        ext_d = 3'h5;
        strobe();
        ext_d = 3'h2;
        settle();
        chk("addr in d", address_in_d, 3'h5);
    endtask
    task automatic t_chip_select();
        cfg_chip_select_d = 3'h7;
        decode_chip_select = 3'h6;
        wr(2'h3, SEL_DIRECTION, 8'h07);
        settle();
        chk("cs d", {pin_oe_d, pin_out_d}, 6'h3e);
    endtask
    task automatic t_data_port();
        wr(2'h0, SEL_DIRECTION, 8'hff);
        cfg_data_port = 1'b1;
        host_bus_data = 8'hc3;
        settle();
        chk("data idle", pin_oe_a, 8'h00);
        host_bus_read = 1'b1;
        settle();
        chk("data drive", {pin_oe_a, pin_out_a}, 16'hffc3);
        rchk(2'h0, SEL_DATA_IN, 8'h00);
        host_bus_read = 1'b0;
        cfg_data_port = 1'b0;
    endtask
    task automatic t_periph();
        peripheral_mode_enable_bit = 1'b1;
        settle();
        chk("periph idle", pin_oe_a, 8'h00);
        peripheral_select_1 = 1'b1;
        host_bus_read = 1'b1;
        settle();
        chk("periph drive", pin_oe_a, 8'hff);
        peripheral_mode_enable_bit = 1'b0;
        host_bus_read = 1'b0;
        settle();
        chk("periph off", {pin_oe_a, pin_out_a}, 16'hffa5);
    endtask
    task automatic t_test_port();
        for (int m = 0; m < 4; m++) begin
            {test_port_select_input, cfg_test_port, test_port_enable_bit} = (m == 3) ? 3'h0 : 3'h1 << m;
            settle();
            chk("test port", test_port_active, m != 3);
        end
    endtask

    initial begin
        {host_wr, host_rd, address_strobe, host_bus_read, cfg_data_port, cfg_test_port, peripheral_mode_enable_bit,
            peripheral_select_0, peripheral_select_1, test_port_select_input, test_port_enable_bit, host_port,
            cfg_bus_type, host_sel, cfg_logic_array_d, cfg_chip_select_d, cfg_address_in_d, decode_chip_select,
            oe_term_d, ext_d, ext_en_d, host_wdata, host_bus_data, cfg_logic_array_a, cfg_logic_array_b,
            cfg_logic_array_c, cfg_address_in_a, cfg_address_in_b, cfg_address_in_c, macrocell_group_first,
            macrocell_group_second, oe_term_a, oe_term_b, oe_term_c, ext_a, ext_en_a, ext_b, ext_en_b, ext_c,
            ext_en_c, host_addr} = '0;
        rst = 1'b1;
        repeat (6) @(negedge core_clk);
        rst = 1'b0;
        t_reset();
        t_gpio();
        t_refuse();
        t_logic_array();
        t_addr_out();
        t_addr_in();
        t_chip_select();
        t_data_port();
        t_periph();
        t_test_port();
        wrap_up();
    end

    initial begin
        #50us;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
